/* File: rtl/escc_pkg.sv */
/*
  shared constants, register map, frame layout and carrier types of the
  eight channel switch control block.
  assumes a 50 MHz system clock and a 16 bit serial frame from the host.
*/
package escc_pkg;

  localparam int CHANNELS = 8;
  localparam int FRAME_BITS = 16;
  localparam int CLK_MHZ = 50;
  localparam int SCLK_MAX_MHZ = 5;
  localparam int RETRY_TIME_US = 10000;
  localparam int PWM_DIV = 64;

  // serial frame: write flag, register address, data byte
  localparam int SPI_WR_BIT = 15;
  localparam int SPI_ADDR_HI = 14;
  localparam int SPI_ADDR_LO = 11;
  localparam int SPI_DATA_HI = 7;

  // serial register addresses
  localparam logic [3:0] SA_OUT_EN = 4'h0;
  localparam logic [3:0] SA_MAP0 = 4'h1;
  localparam logic [3:0] SA_MAP1 = 4'h2;
  localparam logic [3:0] SA_OL_SRC = 4'h3;
  localparam logic [3:0] SA_CLEAR = 4'h4;
  localparam logic [3:0] SA_MONITOR = 4'h5;
  localparam logic [3:0] SA_DUTY0 = 4'h6;
  localparam logic [3:0] SA_DUTY1 = 4'h7;
  localparam logic [3:0] SA_SEL0 = 4'h8;
  localparam logic [3:0] SA_SEL1 = 4'h9;
  localparam logic [3:0] SA_HW_CTRL = 4'ha;

  // reset values: pin zero drives channel 2, pin one drives channel 3
  localparam logic [7:0] MAP0_RST = 8'h04;
  localparam logic [7:0] MAP1_RST = 8'h08;
  localparam int LIMP_CH0 = 2;
  localparam int LIMP_CH1 = 3;
  localparam int HW_SOFT_RST = 0;
  localparam int HW_INRUSH = 1;

  // axi4-lite byte offsets
  localparam logic [7:0] AX_IRQ_STATUS = 8'h00;
  localparam logic [7:0] AX_IRQ_CLEAR = 8'h04;
  localparam logic [7:0] AX_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] AX_CHAN_STATE = 8'h0c;
  localparam logic [7:0] AX_FAULTS = 8'h10;
  localparam logic [7:0] AX_LIMP_CTRL = 8'h14;

  localparam int IRQ_BITS = 4;
  localparam int IRQ_OVERLOAD = 0;
  localparam int IRQ_OVERTEMP = 1;
  localparam int IRQ_FRAME = 2;
  localparam int IRQ_LIMP = 3;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b01,
    SPI_FRAME = 2'b10
  } escc_spi_state_t;

  typedef struct packed {
    logic [7:0] out_en;
    logic [7:0] map0;
    logic [7:0] map1;
    logic [7:0] ol_src;
    logic [7:0] duty0;
    logic [7:0] duty1;
    logic [7:0] sel0;
    logic [7:0] sel1;
    logic [7:0] hw_ctrl;
  } escc_cfg_t;

  typedef struct packed {
    logic [7:0] overload;
    logic [7:0] overtemp;
  } escc_fault_t;

  localparam escc_cfg_t CFG_RST = '{out_en: 8'h00, map0: MAP0_RST, map1: MAP1_RST, ol_src: 8'h00,
                                    duty0: 8'h00, duty1: 8'h00, sel0: 8'h00, sel1: 8'h00, hw_ctrl: 8'h00};

endpackage

/* File: rtl/escc_pwm.sv */
/*
  one internal pwm generator: free running 8 bit ramp compared with a duty.
  assumes a one-cycle tick enable from a divider in the parent.
*/
`timescale 1ns/1ns
`default_nettype none
module escc_pwm import escc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic [7:0] duty,
  output logic pwm
);

  logic [7:0] ramp;
  logic [7:0] next_ramp;
  logic next_pwm;

  always_comb begin
    next_ramp = ramp;
    next_pwm = pwm;
    if (tick) begin
      next_ramp = ramp + 8'h01;
      next_pwm = (ramp < duty);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp <= 8'h00;
      pwm <= 1'b0;
    end else begin
      ramp <= next_ramp;
      pwm <= next_pwm;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/escc_top.sv */
/*
  eight channel high-side switch control: serial frame engine with daisy
  chain, input mapping, limp home routing, latched faults, two pwm
  generators and an axi4-lite slave for interrupts and status.
  assumes all pins are synchronous to aclk and analog detectors give levels.
*/
// Functional notes
// - every control and diagnosis frame is sixteen bits long.
// - bits beyond sixteen pass through to serial out, allowing daisy chains.
// - after reset each input pin drives its default channel without configuration.
// - programmed mapping lets each pin drive any set of channels.
// - limp home routes pin zero to channel 2, pin one to channel 3.
// - with idle low, limp channels follow pins even without digital supply.
// - overload trips the channel off until a serial clear command.
// - in limp home a tripped channel with its pin high retries after restart time.
// - per-channel over-temperature switches the channel off and latches.
// - diagnostic flags are latched and readable over the serial frame.
// - per-channel output monitor bit reports the sensed output state.
// - open-load test current is switched by a serial register.
// - serial access works only with the digital supply present.
// - two independent pwm generators can drive channels.
// - serial output is released while chip select is high.
// - pin zero defaults to channel 2, pin one to channel 3.
`timescale 1ns/1ns
`default_nettype none
module escc_top import escc_pkg::*; #(
  parameter int RETRY_CYCLES = RETRY_TIME_US * CLK_MHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_select_low,
  input wire logic sclk,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  input wire logic direct_input_zero,
  input wire logic direct_input_one,
  input wire logic idle,
  input wire logic vdd_present,
  input wire logic [7:0] overload_detect,
  input wire logic [7:0] overtemp_detect,
  input wire logic [7:0] out_sense,
  output logic [7:0] chan_on,
  output logic [7:0] ol_current_en,
  output logic inrush_drive_mode,
  output logic irq
);

  localparam logic [19:0] RETRY_LAST = 20'(RETRY_CYCLES - 1);
  localparam logic [4:0] FRAME_LEN = 5'(FRAME_BITS);
  localparam logic [5:0] PWM_LAST = 6'(PWM_DIV - 1);

  // serial engine state
  escc_spi_state_t spi_state, next_spi_state;
  logic cs_q, next_cs_q, sclk_q, next_sclk_q;
  logic [15:0] shift, next_shift;
  logic [4:0] cnt, next_cnt;
  logic next_so;
  logic frame_done;

  // core state
  escc_cfg_t cfg, next_cfg;
  escc_fault_t fault, next_fault;
  logic [15:0] resp_word, next_resp_word;
  logic [7:0] output_monitor_diag, next_monitor;
  logic [7:0] next_chan_on, next_ol_en;
  logic [19:0] retry_cnt, next_retry_cnt;
  logic limp_q, next_limp_q;
  logic [5:0] pwm_div, next_pwm_div;
  logic pwm_tick;
  logic [1:0] pwm_out;
  logic [IRQ_BITS-1:0] events;

  // axi and interrupt state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [IRQ_BITS-1:0] irq_status, next_irq_status, irq_enable, next_irq_enable;
  logic limp_force, next_limp_force;

  // frame decode
  logic frame_wr;
  logic [3:0] frame_addr;
  logic [7:0] frame_data;
  logic limp, pins_only;
  logic [7:0] pin_drive, limp_vec, pwm_vec, drive, clr_mask, retry_cand, rd_byte;

  assign frame_wr = shift[SPI_WR_BIT];
  assign frame_addr = shift[SPI_ADDR_HI:SPI_ADDR_LO];
  assign frame_data = shift[SPI_DATA_HI:0];
  assign so_oe = !chip_select_low && vdd_present;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_pwm
      escc_pwm u_pwm (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(pwm_tick),
        .duty(g == 0 ? cfg.duty0 : cfg.duty1),
        .pwm(pwm_out[g])
      );
    end
  endgenerate

  // serial engine
  always_comb begin
    next_spi_state = spi_state;
    next_cs_q = chip_select_low;
    next_sclk_q = sclk;
    next_shift = shift;
    next_cnt = cnt;
    next_so = so_out;
    frame_done = 1'b0;
    unique case (spi_state)
      SPI_IDLE: begin
        if (!chip_select_low && cs_q && vdd_present) begin
          next_spi_state = SPI_FRAME;
          next_shift = resp_word;
          next_so = resp_word[FRAME_BITS-1];
          next_cnt = 5'h00;
        end
      end
      SPI_FRAME: begin
        if (chip_select_low) begin
          next_spi_state = SPI_IDLE;
          frame_done = (cnt == FRAME_LEN) && vdd_present;
        end else if (!vdd_present) begin
          next_spi_state = SPI_IDLE;
        end else if (sclk && !sclk_q) begin
          next_shift = {shift[FRAME_BITS-2:0], si};
          if (cnt != FRAME_LEN) begin
            next_cnt = cnt + 5'h01;
          end
        end else if (!sclk && sclk_q) begin
          next_so = shift[FRAME_BITS-1];
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spi_state <= SPI_IDLE;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      shift <= 16'h0000;
      cnt <= 5'h00;
      so_out <= 1'b0;
    end else begin
      spi_state <= next_spi_state;
      cs_q <= next_cs_q;
      sclk_q <= next_sclk_q;
      shift <= next_shift;
      cnt <= next_cnt;
      so_out <= next_so;
    end
  end

  // channel control, faults, diagnosis
  always_comb begin
    next_cfg = cfg;
    next_fault = fault;
    next_resp_word = resp_word;
    next_monitor = out_sense;
    next_retry_cnt = 20'h00000;
    next_pwm_div = pwm_div + 6'h01;
    pwm_tick = (pwm_div == PWM_LAST);
    if (pwm_tick) begin
      next_pwm_div = 6'h00;
    end
    limp = limp_force || (!vdd_present && !idle);
    pins_only = !vdd_present;
    limp_next_state:
    begin
      next_limp_q = limp;
    end
    pin_drive = ({8{direct_input_zero}} & cfg.map0) | ({8{direct_input_one}} & cfg.map1);
    limp_vec = 8'h00;
    limp_vec[LIMP_CH0] = direct_input_zero;
    limp_vec[LIMP_CH1] = direct_input_one;
    pwm_vec = ({8{pwm_out[0]}} & cfg.sel0) | ({8{pwm_out[1]}} & cfg.sel1);
    if (limp) begin
      drive = limp_vec;
    end else if (pins_only) begin
      drive = 8'h00;
    end else begin
      drive = cfg.out_en | pin_drive | pwm_vec;
    end
    clr_mask = 8'h00;
    rd_byte = output_monitor_diag;
    if (frame_done) begin
      unique case (frame_addr)
        SA_OUT_EN: rd_byte = cfg.out_en;
        SA_MAP0: rd_byte = cfg.map0;
        SA_MAP1: rd_byte = cfg.map1;
        SA_OL_SRC: rd_byte = cfg.ol_src;
        SA_DUTY0: rd_byte = cfg.duty0;
        SA_DUTY1: rd_byte = cfg.duty1;
        SA_SEL0: rd_byte = cfg.sel0;
        SA_SEL1: rd_byte = cfg.sel1;
        SA_HW_CTRL: rd_byte = cfg.hw_ctrl;
        default: rd_byte = output_monitor_diag;
      endcase
      if (frame_wr) begin
        unique case (frame_addr)
          SA_OUT_EN: next_cfg.out_en = frame_data;
          SA_MAP0: next_cfg.map0 = frame_data;
          SA_MAP1: next_cfg.map1 = frame_data;
          SA_OL_SRC: next_cfg.ol_src = frame_data;
          SA_CLEAR: clr_mask = frame_data;
          SA_DUTY0: next_cfg.duty0 = frame_data;
          SA_DUTY1: next_cfg.duty1 = frame_data;
          SA_SEL0: next_cfg.sel0 = frame_data;
          SA_SEL1: next_cfg.sel1 = frame_data;
          SA_HW_CTRL: next_cfg.hw_ctrl = frame_data;
          default: next_cfg = cfg;
        endcase
        if (frame_addr == SA_HW_CTRL && frame_data[HW_SOFT_RST]) begin
          next_cfg = CFG_RST;
          next_cfg.hw_ctrl[HW_INRUSH] = frame_data[HW_INRUSH];
        end
      end
      next_resp_word = {fault.overload | fault.overtemp, rd_byte};
    end
    retry_cand = fault.overload & limp_vec & {8{limp}};
    if (retry_cand != 8'h00) begin
      next_retry_cnt = retry_cnt + 20'h00001;
    end
    if (retry_cand != 8'h00 && retry_cnt == RETRY_LAST) begin
      clr_mask = clr_mask | retry_cand;
      next_retry_cnt = 20'h00000;
    end
    // set wins over clear
    next_fault.overload = (fault.overload & ~clr_mask) | (overload_detect & chan_on);
    next_fault.overtemp = (fault.overtemp & ~clr_mask) | overtemp_detect;
    next_chan_on = drive & ~(fault.overload | fault.overtemp) & ~overload_detect & ~overtemp_detect;
    next_ol_en = pins_only ? 8'h00 : cfg.ol_src;
    events = 4'h0;
    events[IRQ_OVERLOAD] = |(overload_detect & chan_on & ~fault.overload);
    events[IRQ_OVERTEMP] = |(overtemp_detect & ~fault.overtemp);
    events[IRQ_FRAME] = frame_done;
    events[IRQ_LIMP] = limp && !limp_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= CFG_RST;
      fault <= '0;
      resp_word <= 16'h0000;
      output_monitor_diag <= 8'h00;
      retry_cnt <= 20'h00000;
      limp_q <= 1'b0;
      pwm_div <= 6'h00;
      chan_on <= 8'h00;
      ol_current_en <= 8'h00;
      inrush_drive_mode <= 1'b0;
    end else begin
      cfg <= next_cfg;
      fault <= next_fault;
      resp_word <= next_resp_word;
      output_monitor_diag <= next_monitor;
      retry_cnt <= next_retry_cnt;
      limp_q <= next_limp_q;
      pwm_div <= next_pwm_div;
      chan_on <= next_chan_on;
      ol_current_en <= next_ol_en;
      inrush_drive_mode <= next_cfg.hw_ctrl[HW_INRUSH];
    end
  end

  // axi4-lite slave and interrupt registers
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq = |(irq_status & irq_enable);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_irq_enable = irq_enable;
    next_limp_force = limp_force;
    next_irq_status = irq_status;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_held && w_held) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (aw_addr)
        AX_IRQ_CLEAR: if (w_strb[0]) next_irq_status = irq_status & ~w_data[IRQ_BITS-1:0];
        AX_IRQ_ENABLE: if (w_strb[0]) next_irq_enable = w_data[IRQ_BITS-1:0];
        AX_LIMP_CTRL: if (w_strb[0]) next_limp_force = w_data[0];
        AX_IRQ_STATUS, AX_CHAN_STATE, AX_FAULTS: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_irq_status = next_irq_status | events;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        AX_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
        AX_IRQ_CLEAR: next_rdata = 32'h00000000;
        AX_IRQ_ENABLE: next_rdata = {28'h0000000, irq_enable};
        AX_CHAN_STATE: next_rdata = {24'h000000, chan_on};
        AX_FAULTS: next_rdata = {16'h0000, fault.overtemp, fault.overload};
        AX_LIMP_CTRL: next_rdata = {30'h00000000, limp_q, limp_force};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      irq_status <= 4'h0;
      irq_enable <= 4'h0;
      limp_force <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      limp_force <= next_limp_force;
    end
  end

endmodule
`default_nettype wire

/* File: verification/escc_asserts.sv */
/*
  port-level checker for the switch control block.
  assumes it is bound to escc_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module escc_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic chip_select_low,
  input wire logic so_oe,
  input wire logic direct_input_zero,
  input wire logic idle,
  input wire logic vdd_present,
  input wire logic [7:0] overload_detect,
  input wire logic [7:0] overtemp_detect,
  input wire logic [7:0] chan_on,
  input wire logic [7:0] ol_current_en,
  input wire logic irq
);
  logic [7:0] ovl_hit;
  logic [7:0] ot_hold;
  logic cs_q;
  logic [7:0] next_ot_hold;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // over-temperature latch, forgotten at any frame end
  always_comb begin
    next_ot_hold = (!cs_q && chip_select_low) ? overtemp_detect : (ot_hold | overtemp_detect);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovl_hit <= 8'h00;
      ot_hold <= 8'h00;
      cs_q <= 1'b1;
    end else begin
      ovl_hit <= overload_detect & chan_on;
      ot_hold <= next_ot_hold;
      cs_q <= chip_select_low;
    end
  end

  so_release_a: assert property ((chip_select_low || !vdd_present) |-> !so_oe)
    else $error("serial out driven while deselected");
  ol_gate_a: assert property (!vdd_present |=> ol_current_en == 8'h00)
    else $error("open-load current without supply");
  trip_off_a: assert property ((ovl_hit != 8'h00) |-> (chan_on & ovl_hit) == 8'h00)
    else $error("overloaded channel stayed on");
  temp_latch_a: assert property ((chan_on & ot_hold) == 8'h00)
    else $error("overheated channel back on");
  idle_off_a: assert property ((!vdd_present && idle) |=> chan_on == 8'h00)
    else $error("channel on while idle unsupplied");
  limp_route_a: assert property ((!vdd_present && !idle) |=> (chan_on & 8'hf3) == 8'h00)
    else $error("limp drives a non-limp channel");
  limp_pin_a: assert property ((!vdd_present && !idle && !direct_input_zero) |=> !chan_on[2])
    else $error("limp channel 2 on with pin low");
  rd_answer_a: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property ((s_axi_rvalid && !s_axi_rready) |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  wr_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");

  cover property (s_axi_rvalid && s_axi_rready);
  cover property (ot_hold != 8'h00);
  cover property (!vdd_present && !idle && chan_on[2]);
  cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: verification/escc_spi_host.sv */
/*
  behavioural serial master for the switch control block.
  assumes the caller starts a transfer just after a rising aclk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module escc_spi_host #(
  parameter int HALF = 5
) (
  input wire logic aclk,
  input wire logic so_line,
  output logic chip_select_low,
  output logic sclk,
  output logic si
);
  // clock and data idle low, as the pull-downs leave them
  initial begin
    chip_select_low = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // msb first, half period of five aclk cycles keeps sclk at 5 mhz
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    chip_select_low <= 1'b0;
    repeat (HALF) @(posedge aclk);
    for (int i = n - 1; i >= 0; i--) begin
      si <= tx[i];
      repeat (HALF) @(posedge aclk);
      sclk <= 1'b1;
      rx = {rx[30:0], so_line};
      repeat (HALF) @(posedge aclk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge aclk);
    chip_select_low <= 1'b1;
    si <= 1'b0;
    repeat (2 * HALF) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/*
  self-checking bench for the switch control block.
  assumes escc_top, escc_spi_host and escc_asserts are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top import escc_pkg::*;;
  localparam int RETRY = 20;
  localparam int LIMIT = 60000;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, chip_select_low, sclk, si, so_out, so_oe;
  logic direct_input_zero, direct_input_one, idle, vdd_present, inrush_drive_mode, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, overload_detect, overtemp_detect, out_sense, chan_on, ol_current_en;
  logic [31:0] s_axi_wdata, s_axi_rdata, rx;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] rnd;
  int miscompares, comparisons, cycles, m_en, m_map0, m_map1, n, hi0, hi1;
  wire logic so_line;

  assign so_line = so_oe ? so_out : 1'bz;

  escc_top #(.RETRY_CYCLES(RETRY)) u_dut (.*);
  escc_spi_host u_host (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int model_chan();
    return m_en | (direct_input_zero ? m_map0 : 0) | (direct_input_one ? m_map1 : 0);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_on, w_on, b_on;
    aw_on = 1;
    w_on = 1;
    b_on = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (b_on) begin
      @(posedge aclk);
      if (aw_on && s_axi_awready) begin
        aw_on = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_on && s_axi_wready) begin
        w_on = 0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b_on = 0;
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ar_on, r_on;
    ar_on = 1;
    r_on = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (r_on) begin
      @(posedge aclk);
      if (ar_on && s_axi_arready) begin
        ar_on = 0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r_on = 0;
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
    @(posedge aclk);
  endtask

  task automatic spi(input logic wr, input logic [3:0] a, input logic [7:0] d);
    u_host.xfer({16'h0, wr, a, 3'b000, d}, 16, rx);
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {direct_input_zero, direct_input_one, idle, overload_detect, overtemp_detect, out_sense} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    vdd_present = 1'b1;
    rnd = 16'h33ce;
    m_en = 0;
    m_map0 = 32'h4;
    m_map1 = 32'h8;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({so_oe, irq, chan_on}, 0);
    rd_chk(AX_IRQ_ENABLE, 0, RESP_OKAY);
    rd_chk(8'h40, 0, RESP_SLVERR);
    wr_chk(8'h40, 1, RESP_SLVERR);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      if (k > 3) begin
        m_map0 = rnd[7:0];
        m_map1 = rnd[15:8];
        m_en = rnd[11:4];
        spi(1'b1, SA_MAP0, rnd[7:0]);
        spi(1'b1, SA_MAP1, rnd[15:8]);
        spi(1'b1, SA_OUT_EN, rnd[11:4]);
      end
      direct_input_zero <= (k > 3) ? rnd[3] : k[0];
      direct_input_one <= (k > 3) ? rnd[9] : k[1];
      repeat (2) @(posedge aclk);
      check(chan_on, model_chan());
    end
    spi(1'b0, SA_MAP1, 8'h00);
    spi(1'b0, SA_MAP1, 8'h00);
    check(rx[15:0], m_map1);
    u_host.xfer({8'h00, 8'ha5, 1'b1, SA_OUT_EN, 3'b000, 8'h00}, 24, rx);
    m_en = 0;
    check(rx[7:0], 8'ha5);
    u_host.xfer({24'h0, 1'b1, SA_OUT_EN, 3'b000}, 8, rx);
    check(chan_on, model_chan());
    out_sense <= rnd[7:0];
    spi(1'b0, SA_MONITOR, 8'h00);
    spi(1'b0, SA_MONITOR, 8'h00);
    check(rx[15:0], {8'h00, rnd[7:0]});
    spi(1'b1, SA_OL_SRC, rnd[15:8]);
    check(ol_current_en, rnd[15:8]);
    $display("serial test done");
    direct_input_zero <= 1'b0;
    direct_input_one <= 1'b0;
    spi(1'b1, SA_OUT_EN, 8'h60);
    m_en = 32'h60;
    wr_chk(AX_IRQ_CLEAR, 32'hf, RESP_OKAY);
    wr_chk(AX_IRQ_ENABLE, 32'h1, RESP_OKAY);
    overload_detect <= 8'h20;
    overtemp_detect <= 8'h40;
    @(posedge aclk);
    overload_detect <= 8'h00;
    overtemp_detect <= 8'h00;
    repeat (3) @(posedge aclk);
    check({irq, chan_on}, 9'h100);
    rd_chk(AX_FAULTS, 32'h4020, RESP_OKAY);
    spi(1'b0, SA_MONITOR, 8'h00);
    spi(1'b0, SA_MONITOR, 8'h00);
    check(rx[15:8], 8'h60);
    wr_chk(AX_IRQ_CLEAR, 32'h1, RESP_OKAY);
    check(irq, 0);
    spi(1'b1, SA_CLEAR, 8'h60);
    check(chan_on, model_chan());
    rd_chk(AX_FAULTS, 0, RESP_OKAY);
    $display("fault test done");
    spi(1'b1, SA_OUT_EN, 8'hff);
    m_en = 32'hff;
    vdd_present <= 1'b0;
    direct_input_zero <= 1'b1;
    direct_input_one <= 1'b1;
    repeat (2) @(posedge aclk);
    check(chan_on, 32'h0c);
    spi(1'b1, SA_OUT_EN, 8'h00);
    overload_detect <= 8'h04;
    @(posedge aclk);
    overload_detect <= 8'h00;
    repeat (2) @(posedge aclk);
    check(chan_on, 32'h08);
    n = 0;
    while (chan_on[2] !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    check((n + 4 >= RETRY) && (n < 2 * RETRY), 1);
    idle <= 1'b1;
    repeat (2) @(posedge aclk);
    check(chan_on, 0);
    vdd_present <= 1'b1;
    idle <= 1'b0;
    repeat (2) @(posedge aclk);
    check(chan_on, model_chan());
    wr_chk(AX_IRQ_CLEAR, 32'hf, RESP_OKAY);
    wr_chk(AX_LIMP_CTRL, 32'h1, RESP_OKAY);
    rd_chk(AX_LIMP_CTRL, 32'h3, RESP_OKAY);
    rd_chk(AX_CHAN_STATE, 32'h0c, RESP_OKAY);
    rd_chk(AX_IRQ_STATUS, 32'h8, RESP_OKAY);
    wr_chk(AX_LIMP_CTRL, 32'h0, RESP_OKAY);
    spi(1'b1, SA_HW_CTRL, 8'h03);
    m_en = 0;
    m_map0 = 32'h4;
    m_map1 = 32'h8;
    check({inrush_drive_mode, chan_on}, 32'h100 | model_chan());
    $display("limp test done");
    direct_input_zero <= 1'b0;
    direct_input_one <= 1'b0;
    spi(1'b1, SA_OUT_EN, 8'h00);
    spi(1'b1, SA_DUTY0, 8'h40);
    spi(1'b1, SA_SEL0, 8'h01);
    spi(1'b1, SA_DUTY1, 8'hc0);
    spi(1'b1, SA_SEL1, 8'h80);
    repeat (256 * PWM_DIV) begin
      @(posedge aclk);
      hi0 += chan_on[0];
      hi1 += chan_on[7];
    end
    check(hi0, 64 * PWM_DIV);
    check(hi1, 192 * PWM_DIV);
    $display("pwm test done");
    stop_test();
  end
endmodule

bind escc_top escc_asserts u_chk (.*);
`default_nettype wire
